// File: tb/serial_audio_port_sva.sv
// Concurrent checks on the three link wires between the two ends.
// Assumes the source makes the bit clock from ref_clk with 16-cycle halves.
`timescale 1ns/1ps
module serial_audio_port_sva (
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic bclk,
   input wire logic lrclk,
   input wire logic sdata
);
   logic bclk_d;
   logic lr_d;
   logic started;
   logic [4:0] hcnt;
   logic [5:0] rises;
   logic [1:0] lr_seen;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstn);

   ////////////////////////////////////////////////////////////////////////////////
   // Helper counters; the first two word-clock changes are skipped, since the
   // slots before them may be partial after reset release.
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         bclk_d <= 1'b0;
         lr_d <= 1'b0;
         started <= 1'b0;
         hcnt <= 5'h00;
         rises <= 6'h00;
         lr_seen <= 2'h0;
      end else begin
         bclk_d <= bclk;
         lr_d <= lrclk;
         hcnt <= (bclk != bclk_d) ? 5'h00 : hcnt + 5'h01;
         if (bclk != bclk_d) started <= 1'b1;
         if (lrclk != lr_d) begin
            rises <= 6'h00;
            if (lr_seen != 2'h3) lr_seen <= lr_seen + 2'h1;
         end else if (bclk && !bclk_d) begin
            rises <= rises + 6'h01;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Properties on the wire.
   property p_bclk_half;
      started && $changed(bclk) |-> hcnt == 5'h0f;
   endproperty
   property p_bclk_max;
      started |-> hcnt <= 5'h0f;
   endproperty
   property p_slot_len;
      $changed(lrclk) && lr_seen >= 2'h2 |-> rises inside {6'h10, 6'h18, 6'h20};
   endproperty
   property p_lr_edge;
      $changed(lrclk) |-> $fell(bclk);
   endproperty
   property p_sd_edge;
      $changed(sdata) |-> $fell(bclk);
   endproperty
   property p_sd_hold;
      $rose(bclk) |-> (bclk && $stable(sdata) && $stable(lrclk))[*8];
   endproperty
   property p_idle_after_reset;
      $rose(rstn) |-> (!bclk)[*8];
   endproperty
   property p_lr_reset;
      $rose(rstn) |-> !lrclk && !sdata;
   endproperty

   a_bclk_half: assert property (p_bclk_half) else $error("bit clock half period wrong");
   a_bclk_max: assert property (p_bclk_max) else $error("bit clock stopped");
   a_slot_len: assert property (p_slot_len) else $error("slot length wrong");
   a_lr_edge: assert property (p_lr_edge) else $error("word clock off falling edge");
   a_sd_edge: assert property (p_sd_edge) else $error("data off falling edge");
   a_sd_hold: assert property (p_sd_hold) else $error("data moved near rise");
   a_idle_after_reset: assert property (p_idle_after_reset) else $error("early bit clock");
   a_lr_reset: assert property (p_lr_reset) else $error("link not idle at reset");

   // Each ratio is exercised at least once.
   c_slot16: cover property ($changed(lrclk) && lr_seen >= 2'h2 && rises == 6'h10);
   c_slot24: cover property ($changed(lrclk) && lr_seen >= 2'h2 && rises == 6'h18);
   c_slot32: cover property ($changed(lrclk) && lr_seen >= 2'h2 && rises == 6'h20);
endmodule

// File: tb/serial_audio_port_tb.sv
// Self-checking bench: source and receiver joined by the link interface.
// Assumes configuration only changes while both ends are held in reset.
`timescale 1ns/1ps
module serial_audio_input_port_tb;
   logic ref_clk;
   logic rstn;
   serial_audio_pkg::format_e src_fmt;
   serial_audio_pkg::format_e rx_fmt;
   serial_audio_pkg::word_len_e wl_sel;
   serial_audio_pkg::ratio_e ratio;
   logic in_valid;
   logic in_ready;
   logic [23:0] in_left;
   logic [23:0] in_right;
   logic underrun;
   logic sw_ctrl;
   logic ds_req;
   logic sample_valid;
   logic sample_ready;
   logic [23:0] left_sample;
   logic [23:0] right_sample;
   logic overrun;
   serial_audio_pkg::format_e active_format;
   logic ds_act;
   int fails = 0;
   int n_compared = 0;
   logic [23:0] ql[$];
   logic [23:0] qr[$];

   serial_audio_port_if link_bus();

   serial_audio_source i_serial_audio_source (.ref_clk(ref_clk), .rstn(rstn), .link(link_bus),
      .format_sel(src_fmt), .word_len_sel(wl_sel), .ratio_sel(ratio), .in_valid(in_valid),
      .in_ready(in_ready), .in_left(in_left), .in_right(in_right), .underrun(underrun));

   serial_audio_receiver i_serial_audio_receiver (.ref_clk(ref_clk), .rstn(rstn),
      .link(link_bus), .sw_ctrl(sw_ctrl), .format_sel(rx_fmt), .word_len_sel(wl_sel),
      .double_speed_req(ds_req), .sample_valid(sample_valid), .sample_ready(sample_ready),
      .left_sample(left_sample), .right_sample(right_sample), .overrun(overrun),
      .active_format(active_format), .double_speed_active(ds_act));

   serial_audio_port_sva i_serial_audio_port_sva (.ref_clk(ref_clk), .rstn(rstn),
      .bclk(link_bus.bclk), .lrclk(link_bus.lrclk), .sdata(link_bus.sdata));

   ////////////////////////////////////////////////////////////////////////////////
   // Clock, and a monitor that keeps only non-zero pairs, so silent frames sent
   // around reset do not shift the expected order.
   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end

   always @(posedge ref_clk) begin
      if (rstn && sample_valid === 1'b1 && sample_ready && (left_sample | right_sample) != 0) begin
         ql.push_back(left_sample);
         qr.push_back(right_sample);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Shared tasks.
   task automatic check(input logic [23:0] got, input logic [23:0] exp);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic summarize();
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // Resets both ends with the given setup, sends a silent pair then three
   // words, and compares what arrives. A stalled sink looks for overrun, then checks the first left word once released.
   task automatic run_case(input string name, input logic [1:0] sf, input logic [1:0] rf,
         input logic [1:0] wl, input logic [1:0] ra, input logic sw, input logic ds,
         input logic stall);
      logic [23:0] m;
      logic [1:0] ef;
      int n;
      int i;
      m = (wl == 2'h0) ? 24'hffff00 : (wl == 2'h1) ? 24'hffffc0 : (wl == 2'h2) ? 24'hfffff0 : 24'hffffff;
      ef = (sw && rf != 2'h3) ? rf : 2'h0;
      @(negedge ref_clk);
      rstn = 1'b0;
      src_fmt = serial_audio_pkg::format_e'(sf);
      rx_fmt = serial_audio_pkg::format_e'(rf);
      wl_sel = serial_audio_pkg::word_len_e'(wl);
      ratio = serial_audio_pkg::ratio_e'(ra);
      sw_ctrl = sw;
      ds_req = ds;
      sample_ready = !stall;
      repeat (10) @(negedge ref_clk);
      rstn = 1'b1;
      ql.delete();
      qr.delete();
      for (i = 0; i < 4; i++) begin
         n = 0;
         while (in_ready !== 1'b1 && n < 20000) begin
            @(negedge ref_clk);
            n++;
         end
         in_valid = 1'b1;
         in_left = (i == 0) ? 24'h000000 : 24'(24'h91a2b3 + i * 24'h010101);
         in_right = (i == 0) ? 24'h000000 : 24'(24'h3c4d5e + i * 24'h101010);
         @(negedge ref_clk);
         in_valid = 1'b0;
      end
      check(24'(active_format), 24'(ef));
      check(24'(ds_act), 24'(sw & ds));
      n = 0;
      while (((stall && overrun !== 1'b1) || (!stall && ql.size() < 3)) && n < 20000) begin
         @(negedge ref_clk);
         n++;
      end
      if (stall) begin
         check(24'(overrun), 24'h000001);
         sample_ready = 1'b1;
         repeat (4) @(negedge ref_clk);
         check(ql[0], 24'(24'h91a2b3 + 24'h010101) & m);
      end else begin
         check(24'(underrun), 24'h000001);
         check(24'(overrun), 24'h000000);
         for (i = 0; i < 3; i++) begin
            check(ql[i], 24'(24'h91a2b3 + (i + 1) * 24'h010101) & m);
            check(qr[i], 24'(24'h3c4d5e + (i + 1) * 24'h101010) & m);
         end
      end
      $display("%s done", name);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Scenarios: format codes 0 I2S, 1 left, 2 right, 3 reserved.
   task automatic t_i2s_32();
      run_case("i2s 32fs 16b", 2'h0, 2'h0, 2'h0, 2'h0, 1'b1, 1'b0, 1'b0);
   endtask
   task automatic t_pin_48();
      run_case("pin i2s 48fs 24b", 2'h0, 2'h1, 2'h3, 2'h1, 1'b0, 1'b1, 1'b0);
   endtask
   task automatic t_left_48();
      run_case("left 48fs 18b", 2'h1, 2'h1, 2'h1, 2'h1, 1'b1, 1'b1, 1'b0);
   endtask
   task automatic t_left_64();
      run_case("left 64fs 20b", 2'h1, 2'h1, 2'h2, 2'h3, 1'b1, 1'b0, 1'b0);
   endtask
   task automatic t_right_64();
      run_case("right 64fs 24b", 2'h2, 2'h2, 2'h3, 2'h2, 1'b1, 1'b0, 1'b0);
   endtask
   task automatic t_right_32();
      run_case("right 32fs 16b", 2'h2, 2'h2, 2'h0, 2'h0, 1'b1, 1'b1, 1'b0);
   endtask
   task automatic t_reserved();
      run_case("reserved code", 2'h3, 2'h3, 2'h0, 2'h0, 1'b1, 1'b0, 1'b0);
   endtask
   task automatic t_stall();
      run_case("stalled sink", 2'h0, 2'h0, 2'h0, 2'h0, 1'b1, 1'b0, 1'b1);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence and watchdog; each case resets the pair.
   initial begin
      rstn = 1'b0;
      src_fmt = serial_audio_pkg::FMT_I2S;
      rx_fmt = serial_audio_pkg::FMT_I2S;
      wl_sel = serial_audio_pkg::LEN_16;
      ratio = serial_audio_pkg::RATIO_32;
      in_valid = 1'b0;
      in_left = 24'h000000;
      in_right = 24'h000000;
      sw_ctrl = 1'b0;
      ds_req = 1'b0;
      sample_ready = 1'b1;
      t_i2s_32();
      t_pin_48();
      t_left_48();
      t_left_64();
      t_right_64();
      t_right_32();
      t_reserved();
      t_stall();
      summarize();
   end

   // The cases take about 51000 cycles; this 80000-cycle span leaves room.
   initial begin
      #400000;
      fails++;
      summarize();
   end
endmodule

// File: verilog/serial_audio_pkg.sv
// Shared constants and types of the serial audio port: formats, word lengths,
// bit-clock ratios, link timing and reset values.
// Assumes both ends are built from the same copy of this package.
package serial_audio_pkg;

   // Full sample width handed to the audio path, MSB aligned.
   localparam int SAMPLE_W = 24;

   // Serial formats; the reserved code is treated as I2S by the receiver.
   typedef enum logic [1:0] {
      FMT_I2S = 2'b00,
      FMT_LEFT_JUSTIFIED = 2'b01,
      FMT_RIGHT_JUSTIFIED = 2'b10,
      FMT_RSVD = 2'b11
   } format_e;

   // Word lengths carried in each channel slot.
   typedef enum logic [1:0] {
      LEN_16 = 2'b00,
      LEN_18 = 2'b01,
      LEN_20 = 2'b10,
      LEN_24 = 2'b11
   } word_len_e;

   // Bit-clock to sample-rate ratios; the reserved code acts as 64.
   typedef enum logic [1:0] {
      RATIO_32 = 2'b00,
      RATIO_48 = 2'b01,
      RATIO_64 = 2'b10,
      RATIO_RSVD = 2'b11
   } ratio_e;

   // Link timing: the source derives the bit clock from ref_clk.
   localparam int REF_CLK_PERIOD_NS = 5;
   localparam int BCLK_PERIOD_NS = 160;
   localparam int BCLK_HALF_CYC = BCLK_PERIOD_NS / (2 * REF_CLK_PERIOD_NS);
   localparam logic [4:0] BCLK_HALF_LAST = 5'(BCLK_HALF_CYC - 1);

   // Values after reset.
   localparam logic BCLK_RESET = 1'b0;
   localparam logic LRCLK_RESET = 1'b0;
   localparam logic [5:0] FRAME_POS_RESET = 6'h00;
   localparam logic [4:0] BIT_IDX_RESET = 5'h1f;

   // Reference cycles for which the link side stays in reset after release.
   // The bit clock stands still during reset, so this span must cover at
   // least three rising bit-clock edges of the running link.
   localparam logic [7:0] LINK_RST_CYC = 8'h80;

   // Number of data bits in a word of the given length.
   function automatic logic [5:0] word_bits(word_len_e l);
      case (l)
         LEN_16: word_bits = 6'h10;
         LEN_18: word_bits = 6'h12;
         LEN_20: word_bits = 6'h14;
         default: word_bits = 6'h18;
      endcase
   endfunction

   // Number of bit-clock periods in one channel slot.
   function automatic logic [5:0] slot_bits(ratio_e r);
      case (r)
         RATIO_32: slot_bits = 6'h10;
         RATIO_48: slot_bits = 6'h18;
         default: slot_bits = 6'h20;
      endcase
   endfunction

endpackage

// File: verilog/serial_audio_port_if.sv
// Three-wire serial audio link between an audio source and the receiver.
// Assumes the source drives all three wires; the sink only reads them.
`timescale 1ns/1ps
interface serial_audio_port_if;
   logic bclk;
   logic lrclk;
   logic sdata;
   modport source (output bclk, output lrclk, output sdata);
   modport sink (input bclk, input lrclk, input sdata);
endinterface

// File: verilog/serial_audio_receiver.sv
// Receiver end of the serial audio port: captures two-channel words on the
// link's own bit clock and hands MSB-aligned left and right pairs to the
// audio path in the ref_clk domain through a two-entry buffer.
// Assumes the source changes lrclk and sdata away from the rising bit-clock
// edge, and that the configuration inputs only change while audio is idle.
`timescale 1ns/1ps
module serial_audio_receiver (
   input wire logic ref_clk,
   input wire logic rstn,
   serial_audio_port_if.sink link,
   input wire logic sw_ctrl,
   input wire serial_audio_pkg::format_e format_sel,
   input wire serial_audio_pkg::word_len_e word_len_sel,
   input wire logic double_speed_req,
   output logic sample_valid,
   input wire logic sample_ready,
   output logic [23:0] left_sample,
   output logic [23:0] right_sample,
   output logic overrun,
   output serial_audio_pkg::format_e active_format,
   output logic double_speed_active
);

   // Link-domain state, clocked by the incoming bit clock.
   typedef struct packed {
      logic [1:0] rst_sync;
      logic [5:0] cfg_s1;
      logic [5:0] cfg_s2;
      logic [1:0] lr_p;
      logic [1:0] d_p;
      logic lr_d1;
      logic eff_d;
      logic [4:0] idx;
      logic [23:0] acc;
      logic [23:0] rj_sh;
      logic [23:0] left_hold;
      logic left_ok;
      logic [23:0] xl;
      logic [23:0] xr;
      logic tgl;
   } link_s;

   // Reference-domain state: configuration, toggle sync and output buffer.
   typedef struct packed {
      logic [5:0] cfg_q;
      logic tg_s1;
      logic tg_s2;
      logic tg_s3;
      logic out_valid;
      logic [23:0] out_l;
      logic [23:0] out_r;
      logic sp_valid;
      logic [23:0] sp_l;
      logic [23:0] sp_r;
      logic overrun;
      logic [1:0] fmt;
      logic dbl;
      logic [7:0] rst_cnt;
      logic link_rst_n;
   } ref_s;

   link_s link_reg;
   link_s link_next;
   ref_s ref_reg;
   ref_s ref_next;

   ////////////////////////////////////////////////////////////////////////////
   // Link domain. The pins pass a two-stage pipeline first; both are delayed
   // alike, so the word clock to data relation is kept.
   always_comb begin
      logic sw;
      serial_audio_pkg::format_e fmt;
      logic i2s;
      logic rj;
      logic [5:0] wl;
      logic lr;
      logic d;
      logic eff;
      logic left_ch;
      logic [23:0] word;
      logic [5:0] sh;
      logic [4:0] bpos;
      sw = link_reg.cfg_s2[5];
      fmt = serial_audio_pkg::format_e'(link_reg.cfg_s2[4:3]);
      // Pin control forces I2S; register control may pick a justified format.
      if (!sw || fmt == serial_audio_pkg::FMT_RSVD) begin
         fmt = serial_audio_pkg::FMT_I2S;
      end
      i2s = (fmt == serial_audio_pkg::FMT_I2S);
      rj = (fmt == serial_audio_pkg::FMT_RIGHT_JUSTIFIED);
      wl = serial_audio_pkg::word_bits(serial_audio_pkg::word_len_e'(link_reg.cfg_s2[2:1]));
      lr = link_reg.lr_p[1];
      d = link_reg.d_p[1];
      word = 24'h000000;
      sh = 6'h00;
      bpos = 5'h00;
      left_ch = 1'b0;
      link_next = link_reg;
      link_next.rst_sync = {link_reg.rst_sync[0], ref_reg.link_rst_n};
      link_next.cfg_s1 = ref_reg.cfg_q;
      link_next.cfg_s2 = link_reg.cfg_s1;
      link_next.lr_p = {link_reg.lr_p[0], link.lrclk};
      link_next.d_p = {link_reg.d_p[0], link.sdata};
      link_next.lr_d1 = lr;
      // I2S data trails the word clock by one bit, so the word clock is
      // delayed one bit to line it up like the left-justified case.
      eff = i2s ? link_reg.lr_d1 : lr;
      link_next.eff_d = eff;
      // Continuous history of the last 24 bits for right-justified words.
      link_next.rj_sh = {link_reg.rj_sh[22:0], d};
      if (eff != link_reg.eff_d) begin
         // Slot boundary: the finished word belongs to the old channel.
         if (rj) begin
            // Leading slot bits fall off the top; the word ends MSB aligned.
            sh = 6'h18 - wl;
            word = link_reg.rj_sh << sh;
         end else begin
            word = link_reg.acc;
         end
         left_ch = i2s ? ~link_reg.eff_d : link_reg.eff_d;
         if (left_ch) begin
            link_next.left_hold = word;
            link_next.left_ok = 1'b1;
         end else if (link_reg.left_ok) begin
            // A pair leaves once per frame, left first, with a toggle event.
            link_next.xl = link_reg.left_hold;
            link_next.xr = word;
            link_next.tgl = ~link_reg.tgl;
            link_next.left_ok = 1'b0;
         end
         // The bit on this edge is the MSB of the new word.
         link_next.acc = {d, 23'h000000};
         link_next.idx = 5'h01;
      end else begin
         // Bits past the word length stay zero, whatever the slot length.
         if ({1'b0, link_reg.idx} < wl) begin
            bpos = 5'h17 - link_reg.idx;
            link_next.acc[bpos] = d;
         end
         if (link_reg.idx != 5'h1f) begin
            link_next.idx = link_reg.idx + 5'h01;
         end
      end
   end

   // Link-domain register; its reset is the stretched reset brought over by
   // two flops, since rstn alone ends before the bit clock starts to run.
   always_ff @(posedge link.bclk) begin
      if (!link_reg.rst_sync[1]) begin
         link_reg <= '0;
         link_reg.rst_sync <= link_next.rst_sync;
         link_reg.idx <= serial_audio_pkg::BIT_IDX_RESET;
      end else begin
         link_reg <= link_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Reference domain. The pair words are held for a whole frame after each
   // toggle, far longer than the toggle's three-flop path, so they are read
   // directly once the synchronised toggle moves.
   always_comb begin
      logic push;
      push = (ref_reg.tg_s2 ^ ref_reg.tg_s3) && ref_reg.link_rst_n;
      ref_next = ref_reg;
      // Hold the link side in reset for a few bit-clock periods after release.
      // Toggles seen before it leaves are stale and must not push a pair.
      if (ref_reg.rst_cnt != serial_audio_pkg::LINK_RST_CYC) begin
         ref_next.rst_cnt = ref_reg.rst_cnt + 8'h01;
      end
      ref_next.link_rst_n = (ref_reg.rst_cnt == serial_audio_pkg::LINK_RST_CYC);
      ref_next.cfg_q = {sw_ctrl, format_sel, word_len_sel, double_speed_req};
      ref_next.tg_s1 = link_reg.tgl;
      ref_next.tg_s2 = ref_reg.tg_s1;
      ref_next.tg_s3 = ref_reg.tg_s2;
      // Report the format really in use and the speed mode.
      if (sw_ctrl && format_sel != serial_audio_pkg::FMT_RSVD) begin
         ref_next.fmt = format_sel;
      end else begin
         ref_next.fmt = serial_audio_pkg::FMT_I2S;
      end
      ref_next.dbl = sw_ctrl & double_speed_req;
      // Drain first, so a pop and a push in one cycle never look full.
      if (ref_reg.out_valid && sample_ready) begin
         if (ref_reg.sp_valid) begin
            ref_next.out_l = ref_reg.sp_l;
            ref_next.out_r = ref_reg.sp_r;
            ref_next.sp_valid = 1'b0;
         end else begin
            ref_next.out_valid = 1'b0;
         end
      end
      // The link cannot be stalled; a third pending pair is dropped.
      if (push) begin
         if (!ref_next.out_valid) begin
            ref_next.out_l = link_reg.xl;
            ref_next.out_r = link_reg.xr;
            ref_next.out_valid = 1'b1;
         end else if (!ref_next.sp_valid) begin
            ref_next.sp_l = link_reg.xl;
            ref_next.sp_r = link_reg.xr;
            ref_next.sp_valid = 1'b1;
         end else begin
            ref_next.overrun = 1'b1;
         end
      end
   end

   // Reference-domain register with synchronous active-low reset.
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         ref_reg <= '0;
      end else begin
         ref_reg <= ref_next;
      end
   end

   // Every output is a flip-flop.
   assign sample_valid = ref_reg.out_valid;
   assign left_sample = ref_reg.out_l;
   assign right_sample = ref_reg.out_r;
   assign overrun = ref_reg.overrun;
   assign active_format = serial_audio_pkg::format_e'(ref_reg.fmt);
   assign double_speed_active = ref_reg.dbl;

endmodule

// File: verilog/serial_audio_source.sv
// Audio source end: makes the bit clock from ref_clk, frames stereo pairs
// in I2S or justified format and shifts them out MSB first.
// Assumes in_left and in_right are MSB aligned and held while in_valid is high.
`timescale 1ns/1ps
module serial_audio_source (
   input wire logic ref_clk,
   input wire logic rstn,
   serial_audio_port_if.source link,
   input wire serial_audio_pkg::format_e format_sel,
   input wire serial_audio_pkg::word_len_e word_len_sel,
   input wire serial_audio_pkg::ratio_e ratio_sel,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [23:0] in_left,
   input wire logic [23:0] in_right,
   output logic underrun
);

   typedef struct packed {
      logic [4:0] div;
      logic bclk;
      logic [5:0] k;
      logic lr;
      logic sd;
      logic [23:0] cur_l;
      logic [23:0] cur_r;
      logic [23:0] hold_l;
      logic [23:0] hold_r;
      logic hold_valid;
      logic in_ready;
      logic underrun;
   } src_s;

   src_s src_reg;
   src_s src_next;

   ////////////////////////////////////////////////////////////////////////////
   // Divider, frame position and serialiser. Outputs change on the falling
   // bit-clock edge so that the receiver sees stable data at the rising one.
   always_comb begin
      logic i2s;
      logic rj;
      logic [5:0] s;
      logic [5:0] wl;
      logic [6:0] flast;
      logic [5:0] kn;
      logic [5:0] p;
      logic [5:0] j;
      logic [5:0] off;
      logic [5:0] bi;
      logic [23:0] w;
      i2s = (format_sel != serial_audio_pkg::FMT_LEFT_JUSTIFIED) &&
            (format_sel != serial_audio_pkg::FMT_RIGHT_JUSTIFIED);
      rj = (format_sel == serial_audio_pkg::FMT_RIGHT_JUSTIFIED);
      s = serial_audio_pkg::slot_bits(ratio_sel);
      wl = serial_audio_pkg::word_bits(word_len_sel);
      flast = {s, 1'b0} - 7'h01;
      kn = 6'h00;
      p = 6'h00;
      j = 6'h00;
      off = 6'h00;
      bi = 6'h00;
      w = 24'h000000;
      src_next = src_reg;
      src_next.div = src_reg.div + 5'h01;
      if (src_reg.div == serial_audio_pkg::BCLK_HALF_LAST) begin
         src_next.div = 5'h00;
         src_next.bclk = ~src_reg.bclk;
         if (src_reg.bclk) begin
            kn = ({1'b0, src_reg.k} >= flast) ? 6'h00 : src_reg.k + 6'h01;
            // I2S data trails the word clock by one bit period.
            if (i2s) begin
               p = (kn == 6'h00) ? flast[5:0] : kn - 6'h01;
            end else begin
               p = kn;
            end
            if (p == 6'h00) begin
               // A frame with no new pair sends silence and is flagged.
               src_next.cur_l = src_reg.hold_valid ? src_reg.hold_l : 24'h000000;
               src_next.cur_r = src_reg.hold_valid ? src_reg.hold_r : 24'h000000;
               src_next.underrun = src_reg.underrun | ~src_reg.hold_valid;
               src_next.hold_valid = 1'b0;
            end
            j = (p >= s) ? p - s : p;
            w = (p >= s) ? src_next.cur_r : src_next.cur_l;
            if (rj) begin
               // Right-justified: the LSB lands in the last slot bit; a word longer than the slot sends only its top slot bits.
               off = (s > wl) ? s - wl : 6'h00;
               bi = 6'h17 - (j - off);
               src_next.sd = (j >= off) && ((j - off) < wl) && w[bi[4:0]];
            end else begin
               bi = 6'h17 - j;
               src_next.sd = (j < wl) && w[bi[4:0]];
            end
            src_next.k = kn;
            // Left channel while the word clock is low in I2S, high otherwise.
            src_next.lr = i2s ? (kn >= s) : (kn < s);
         end
      end
      if (in_valid && src_reg.in_ready) begin
         src_next.hold_l = in_left;
         src_next.hold_r = in_right;
         src_next.hold_valid = 1'b1;
      end
      src_next.in_ready = ~src_next.hold_valid;
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register with synchronous active-low reset.
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         src_reg <= '0;
         src_reg.bclk <= serial_audio_pkg::BCLK_RESET;
         src_reg.lr <= serial_audio_pkg::LRCLK_RESET;
         src_reg.k <= serial_audio_pkg::FRAME_POS_RESET;
      end else begin
         src_reg <= src_next;
      end
   end

   // Every output is a flip-flop.
   assign link.bclk = src_reg.bclk;
   assign link.lrclk = src_reg.lr;
   assign link.sdata = src_reg.sd;
   assign in_ready = src_reg.in_ready;
   assign underrun = src_reg.underrun;

endmodule
